//--- src/accel_config_register_bank.sv
// Configuration, identity and buffer read-port register bank of the three-axis motion sensor.
//
// Summary of operation
// (R1) Y low returns [7:0] or [11:4].
// (R2) Y high returns [11:8] or [3:0].
// (R3) Z pair splits like Y pair.
// (R4) Y skip steps over both Y registers.
// (R5) Z skip steps over both Z registers.
// (R6) Revision register read-only, BCD major.minor.
// (R7) Identity register read-only fixed eight-bit code.
// (R8) State register shows mode, gate error, count.
// (R9) Control A: range, self-test, reset, active.
// (R10) Control B: power modes, order, increment, fast.
// (R11) Control C: wake and sleep rates, decimation.
// (R12) Control D: interrupt sources, pin, trigger enable.
// (R13) Control E: axis skips and hibernate enable.
// (R14) Twelve-bit active idle time, low/high split.
// (R15) Twelve-bit dormant idle time, low/high split.
// (R16) Twelve-bit inactivity count, low/high split.
// (R17) Host writes count low at least one.
// (R18) Pointer advances; buffer axes wrap around.
// (R19) Writes to read-only registers are ignored.
`timescale 1ns/1ps
module accel_config_register_bank #(
   parameter logic [7:0] REVISION_CODE = 8'h10, // Two BCD digits, here 1.0.
   parameter logic [7:0] IDENTITY_CODE = 8'h5a  // Value is arbitrary.
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic xfer_start,
   input wire logic [7:0] start_addr,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic [11:0] buf_y_sample,
   input wire logic [11:0] buf_z_sample,
   input wire logic [1:0] op_mode,
   input wire logic gate_error,
   input wire logic [4:0] gate_error_count,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic [7:0] sensor_control_a,
   output logic [7:0] sensor_control_b,
   output logic [7:0] sensor_control_c,
   output logic [7:0] sensor_control_d,
   output logic [7:0] sensor_control_e,
   output logic [11:0] active_idle,
   output logic [11:0] dormant_idle,
   output logic [11:0] inactivity_count
);

   ////////////////////////////////////////////////////////////////////////////////
   // Address pointer and its auto-increment.
   ////////////////////////////////////////////////////////////////////////////////

   logic [7:0] read_ptr; // Register addressed by the next byte.
   logic [7:0] next_read_ptr; // Pointer after a read byte.
   logic [7:0] read_value; // Byte the pointer selects now.
   logic take_write; // A write that is not shadowed by a read.

   // Pick the first buffer axis after axis k that is not skipped, wrapping around.
   // Axes are 0 for X, 1 for Y and 2 for Z.
   function automatic logic [7:0] after_axis(input logic [1:0] k, input logic xs, input logic ys,
                                              input logic zs);
      logic [7:0] low_addr [3];
      logic skip [3];
      logic [7:0] res;
      low_addr[0] = accel_regs_pkg::ADDR_X_LOW;
      low_addr[1] = accel_regs_pkg::ADDR_Y_LOW;
      low_addr[2] = accel_regs_pkg::ADDR_Z_LOW;
      skip[0] = xs;
      skip[1] = ys;
      skip[2] = zs;
      // With every axis skipped the read leaves the buffer block.
      res = accel_regs_pkg::ADDR_REVISION;
      for (int i = 3; i >= 1; i--) begin
         if (!skip[(k + i) % 3]) begin
            res = low_addr[(k + i) % 3];
         end
      end
      return res;
   endfunction : after_axis

   // Successor of the pointer after a read byte.
   always_comb begin
      logic fast;
      logic xs;
      logic ys;
      logic zs;
      fast = sensor_control_b[accel_regs_pkg::B_FAST_READ];
      xs = sensor_control_e[accel_regs_pkg::E_X_SKIP];
      ys = sensor_control_e[accel_regs_pkg::E_Y_SKIP];
      zs = sensor_control_e[accel_regs_pkg::E_Z_SKIP];
      case (read_ptr)
         // Fast read visits only the low byte of each enabled axis. [R18]
         accel_regs_pkg::ADDR_X_LOW: begin
            next_read_ptr = fast ? after_axis(2'd0, xs, ys, zs) : accel_regs_pkg::ADDR_X_HIGH;
         end
         accel_regs_pkg::ADDR_X_HIGH: begin
            next_read_ptr = after_axis(2'd0, xs, ys, zs); // [R4] [R5] [R18]
         end
         accel_regs_pkg::ADDR_Y_LOW: begin
            next_read_ptr = fast ? after_axis(2'd1, xs, ys, zs) : accel_regs_pkg::ADDR_Y_HIGH;
         end
         accel_regs_pkg::ADDR_Y_HIGH: begin
            next_read_ptr = after_axis(2'd1, xs, ys, zs); // [R5] [R18]
         end
         accel_regs_pkg::ADDR_Z_LOW: begin
            next_read_ptr = fast ? after_axis(2'd2, xs, ys, zs) : accel_regs_pkg::ADDR_Z_HIGH;
         end
         accel_regs_pkg::ADDR_Z_HIGH: begin
            next_read_ptr = after_axis(2'd2, xs, ys, zs); // [R4] [R18]
         end
         default: begin
            // Outside the buffer block the pointer simply counts up. [R18]
            next_read_ptr = read_ptr + accel_regs_pkg::ADDR_STEP;
         end
      endcase
   end

   // A read and a write in the same cycle cannot both be honoured; the read wins.
   assign take_write = wr_strobe && !rd_strobe;

   // The pointer loads on a transfer start and steps after every byte.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         read_ptr <= accel_regs_pkg::READ_ZERO;
      end else if (xfer_start) begin
         read_ptr <= start_addr;
      end else if (rd_strobe) begin
         read_ptr <= next_read_ptr; // [R18]
      end else if (take_write) begin
         read_ptr <= read_ptr + accel_regs_pkg::ADDR_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read multiplexer.
   ////////////////////////////////////////////////////////////////////////////////

   // Select the byte at the pointer; unmapped addresses read as zero.
   always_comb begin
      logic order;
      order = sensor_control_b[accel_regs_pkg::B_BYTE_ORDER];
      case (read_ptr)
         accel_regs_pkg::ADDR_Y_LOW: begin
            read_value = order ? buf_y_sample[11:4] : buf_y_sample[7:0]; // [R1]
         end
         accel_regs_pkg::ADDR_Y_HIGH: begin
            read_value = order ? {accel_regs_pkg::NIBBLE_ZERO, buf_y_sample[3:0]} :
                                 {accel_regs_pkg::NIBBLE_ZERO, buf_y_sample[11:8]}; // [R2]
         end
         accel_regs_pkg::ADDR_Z_LOW: begin
            read_value = order ? buf_z_sample[11:4] : buf_z_sample[7:0]; // [R3]
         end
         accel_regs_pkg::ADDR_Z_HIGH: begin
            read_value = order ? {accel_regs_pkg::NIBBLE_ZERO, buf_z_sample[3:0]} :
                                 {accel_regs_pkg::NIBBLE_ZERO, buf_z_sample[11:8]}; // [R3]
         end
         accel_regs_pkg::ADDR_REVISION: read_value = REVISION_CODE; // [R6]
         accel_regs_pkg::ADDR_IDENTITY: read_value = IDENTITY_CODE; // [R7]
         accel_regs_pkg::ADDR_STATE: begin
            read_value = {gate_error, gate_error_count, op_mode}; // [R8]
         end
         accel_regs_pkg::ADDR_CTL_A: read_value = sensor_control_a;
         accel_regs_pkg::ADDR_CTL_B: read_value = sensor_control_b;
         accel_regs_pkg::ADDR_CTL_C: read_value = sensor_control_c;
         accel_regs_pkg::ADDR_CTL_D: read_value = sensor_control_d;
         accel_regs_pkg::ADDR_CTL_E: read_value = sensor_control_e;
         accel_regs_pkg::ADDR_ACT_IDLE_LOW: read_value = active_idle[7:0]; // [R14]
         accel_regs_pkg::ADDR_ACT_IDLE_HIGH: read_value = {accel_regs_pkg::NIBBLE_ZERO, active_idle[11:8]};
         accel_regs_pkg::ADDR_DOR_IDLE_LOW: read_value = dormant_idle[7:0]; // [R15]
         accel_regs_pkg::ADDR_DOR_IDLE_HIGH: read_value = {accel_regs_pkg::NIBBLE_ZERO, dormant_idle[11:8]};
         accel_regs_pkg::ADDR_INACT_LOW: read_value = inactivity_count[7:0]; // [R16]
         accel_regs_pkg::ADDR_INACT_HIGH: read_value = {accel_regs_pkg::NIBBLE_ZERO, inactivity_count[11:8]};
         default: read_value = accel_regs_pkg::READ_ZERO;
      endcase
   end

   // Register the read byte so the output comes straight from a flip-flop.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_data <= accel_regs_pkg::READ_ZERO;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_strobe && !xfer_start;
         if (rd_strobe && !xfer_start) begin
            rd_data <= read_value;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Writable registers.
   ////////////////////////////////////////////////////////////////////////////////

   logic wr_ok; // A write that lands on the current pointer.
   logic soft_reset; // Soft reset request written this cycle.

   assign wr_ok = take_write && !xfer_start;
   // Soft reset acts once and is never stored, so the bit always reads back zero.
   assign soft_reset = wr_ok && (read_ptr == accel_regs_pkg::ADDR_CTL_A) && wr_data[accel_regs_pkg::A_SOFT_RESET];

   // Control registers; a write to any read-only address falls through to nothing. [R19]
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sensor_control_a <= accel_regs_pkg::RST_CTL_A;
         sensor_control_b <= accel_regs_pkg::RST_CTL_B;
         sensor_control_c <= accel_regs_pkg::RST_CTL_C;
         sensor_control_d <= accel_regs_pkg::RST_CTL_D;
         sensor_control_e <= accel_regs_pkg::RST_CTL_E;
      end else if (soft_reset) begin
         // Soft reset returns every control field to its power-on value.
         sensor_control_a <= accel_regs_pkg::RST_CTL_A;
         sensor_control_b <= accel_regs_pkg::RST_CTL_B;
         sensor_control_c <= accel_regs_pkg::RST_CTL_C;
         sensor_control_d <= accel_regs_pkg::RST_CTL_D;
         sensor_control_e <= accel_regs_pkg::RST_CTL_E;
      end else if (wr_ok) begin
         case (read_ptr)
            accel_regs_pkg::ADDR_CTL_A: sensor_control_a <= wr_data; // [R9]
            accel_regs_pkg::ADDR_CTL_B: sensor_control_b <= wr_data; // [R10]
            accel_regs_pkg::ADDR_CTL_C: sensor_control_c <= wr_data; // [R11]
            accel_regs_pkg::ADDR_CTL_D: sensor_control_d <= wr_data; // [R12]
            accel_regs_pkg::ADDR_CTL_E: sensor_control_e <= wr_data; // [R13]
            default: begin
               // Read-only and unmapped addresses keep their contents. [R19]
            end
         endcase
      end
   end

   // Twelve-bit timing values; the high byte keeps only its low nibble.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         active_idle <= accel_regs_pkg::RST_COUNT12;
         dormant_idle <= accel_regs_pkg::RST_COUNT12;
         inactivity_count <= accel_regs_pkg::RST_COUNT12;
      end else if (soft_reset) begin
         active_idle <= accel_regs_pkg::RST_COUNT12;
         dormant_idle <= accel_regs_pkg::RST_COUNT12;
         inactivity_count <= accel_regs_pkg::RST_COUNT12;
      end else if (wr_ok) begin
         case (read_ptr)
            accel_regs_pkg::ADDR_ACT_IDLE_LOW: active_idle[7:0] <= wr_data; // [R14]
            accel_regs_pkg::ADDR_ACT_IDLE_HIGH: active_idle[11:8] <= wr_data[3:0]; // [R14]
            accel_regs_pkg::ADDR_DOR_IDLE_LOW: dormant_idle[7:0] <= wr_data; // [R15]
            accel_regs_pkg::ADDR_DOR_IDLE_HIGH: dormant_idle[11:8] <= wr_data[3:0]; // [R15]
            // A zero low byte here leaves automatic sleep off; the host must write one or more. [R17]
            accel_regs_pkg::ADDR_INACT_LOW: inactivity_count[7:0] <= wr_data; // [R16]
            accel_regs_pkg::ADDR_INACT_HIGH: inactivity_count[11:8] <= wr_data[3:0]; // [R16]
            default: begin
               // Other addresses leave the timing values alone.
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   ////////////////////////////////////////////////////////////////////////////////

   logic rd_go; // Read byte taken this cycle.
   assign rd_go = rd_strobe && !xfer_start;

   property p_y_low_order;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && read_ptr == accel_regs_pkg::ADDR_Y_LOW)
         |=> rd_valid && rd_data == ($past(sensor_control_b[accel_regs_pkg::B_BYTE_ORDER]) ?
             $past(buf_y_sample[11:4]) : $past(buf_y_sample[7:0]));
   endproperty
   a_y_low_order: assert property (p_y_low_order) else $error("Y low byte wrong."); // [R1]

   property p_y_high_order;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && read_ptr == accel_regs_pkg::ADDR_Y_HIGH && sensor_control_b[accel_regs_pkg::B_BYTE_ORDER])
         |=> rd_data == {4'h0, $past(buf_y_sample[3:0])};
   endproperty
   a_y_high_order: assert property (p_y_high_order) else $error("Y high byte wrong."); // [R2]

   property p_z_high_le;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && read_ptr == accel_regs_pkg::ADDR_Z_HIGH && !sensor_control_b[accel_regs_pkg::B_BYTE_ORDER])
         |=> rd_data == {4'h0, $past(buf_z_sample[11:8])};
   endproperty
   a_z_high_le: assert property (p_z_high_le) else $error("Z high byte wrong."); // [R3]

   property p_y_skipped;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && sensor_control_e[accel_regs_pkg::E_Y_SKIP] && read_ptr != accel_regs_pkg::ADDR_Y_LOW)
         |=> read_ptr != accel_regs_pkg::ADDR_Y_LOW && read_ptr != accel_regs_pkg::ADDR_Y_HIGH;
   endproperty
   a_y_skipped: assert property (p_y_skipped) else $error("Pointer entered skipped Y."); // [R4]

   property p_z_skipped;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && sensor_control_e[accel_regs_pkg::E_Z_SKIP] && read_ptr != accel_regs_pkg::ADDR_Z_LOW)
         |=> read_ptr != accel_regs_pkg::ADDR_Z_LOW && read_ptr != accel_regs_pkg::ADDR_Z_HIGH;
   endproperty
   a_z_skipped: assert property (p_z_skipped) else $error("Pointer entered skipped Z."); // [R5]

   property p_ident_read;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && read_ptr == accel_regs_pkg::ADDR_REVISION && !xfer_start)
         |=> rd_data == REVISION_CODE ##0 (read_ptr == accel_regs_pkg::ADDR_IDENTITY);
   endproperty
   a_ident_read: assert property (p_ident_read) else $error("Revision read or step wrong."); // [R6] [R18]

   property p_ro_write;
      @(posedge sys_clk) disable iff (rst)
      (wr_ok && read_ptr >= accel_regs_pkg::ADDR_Y_LOW && read_ptr <= accel_regs_pkg::ADDR_STATE)
         |=> $stable(sensor_control_a) && $stable(sensor_control_e) && $stable(inactivity_count);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("Read-only write changed state."); // [R19]

   property p_idle_split;
      @(posedge sys_clk) disable iff (rst)
      (wr_ok && read_ptr == accel_regs_pkg::ADDR_ACT_IDLE_HIGH)
         |=> active_idle[11:8] == $past(wr_data[3:0]) && $stable(active_idle[7:0]);
   endproperty
   a_idle_split: assert property (p_idle_split) else $error("Active idle high wrong."); // [R14]

   property p_count_low;
      @(posedge sys_clk) disable iff (rst)
      (wr_ok && read_ptr == accel_regs_pkg::ADDR_INACT_LOW)
         |=> inactivity_count[7:0] == $past(wr_data);
   endproperty
   a_count_low: assert property (p_count_low) else $error("Inactivity low byte wrong."); // [R16]

   property p_ctl_e_write;
      @(posedge sys_clk) disable iff (rst)
      (wr_ok && read_ptr == accel_regs_pkg::ADDR_CTL_E) |=> sensor_control_e == $past(wr_data);
   endproperty
   a_ctl_e_write: assert property (p_ctl_e_write) else $error("Control E not stored."); // [R13]

   property p_fast_wrap;
      @(posedge sys_clk) disable iff (rst)
      (rd_go && read_ptr == accel_regs_pkg::ADDR_Z_LOW && sensor_control_b[accel_regs_pkg::B_FAST_READ]
       && !sensor_control_e[accel_regs_pkg::E_X_SKIP]) |=> read_ptr == accel_regs_pkg::ADDR_X_LOW;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("Fast read did not wrap."); // [R18]

endmodule : accel_config_register_bank

//--- src/accel_regs_pkg.sv
// Package with addresses, field positions and reset values of the sensor configuration register bank.
package accel_regs_pkg;
   // Register addresses on the serial register bus.
   localparam logic [7:0] ADDR_X_LOW = 8'h0c;
   localparam logic [7:0] ADDR_X_HIGH = 8'h0d;
   localparam logic [7:0] ADDR_Y_LOW = 8'h0e;
   localparam logic [7:0] ADDR_Y_HIGH = 8'h0f;
   localparam logic [7:0] ADDR_Z_LOW = 8'h10;
   localparam logic [7:0] ADDR_Z_HIGH = 8'h11;
   localparam logic [7:0] ADDR_REVISION = 8'h12;
   localparam logic [7:0] ADDR_IDENTITY = 8'h13;
   localparam logic [7:0] ADDR_STATE = 8'h14;
   localparam logic [7:0] ADDR_CTL_A = 8'h15;
   localparam logic [7:0] ADDR_CTL_B = 8'h16;
   localparam logic [7:0] ADDR_CTL_C = 8'h17;
   localparam logic [7:0] ADDR_CTL_D = 8'h18;
   localparam logic [7:0] ADDR_CTL_E = 8'h19;
   localparam logic [7:0] ADDR_ACT_IDLE_LOW = 8'h1a;
   localparam logic [7:0] ADDR_ACT_IDLE_HIGH = 8'h1b;
   localparam logic [7:0] ADDR_DOR_IDLE_LOW = 8'h1c;
   localparam logic [7:0] ADDR_DOR_IDLE_HIGH = 8'h1d;
   localparam logic [7:0] ADDR_INACT_LOW = 8'h1e;
   localparam logic [7:0] ADDR_INACT_HIGH = 8'h1f;
   // Step between consecutive register addresses.
   localparam logic [7:0] ADDR_STEP = 8'h01;
   // Reset values of the writable registers.
   localparam logic [7:0] RST_CTL_A = 8'h00;
   localparam logic [7:0] RST_CTL_B = 8'h00;
   localparam logic [7:0] RST_CTL_C = 8'h00;
   localparam logic [7:0] RST_CTL_D = 8'h01;
   localparam logic [7:0] RST_CTL_E = 8'h00;
   localparam logic [11:0] RST_COUNT12 = 12'h000;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   // Field positions in the second control register.
   localparam int B_FAST_READ = 0;
   localparam int B_AINC_TEMP = 1;
   localparam int B_BYTE_ORDER = 2;
   // Field positions in the first control register.
   localparam int A_SOFT_RESET = 7;
   // Field positions in the fifth control register.
   localparam int E_X_SKIP = 5;
   localparam int E_Y_SKIP = 4;
   localparam int E_Z_SKIP = 3;
   localparam int E_HIBERNATE = 0;
endpackage : accel_regs_pkg

//--- tb/reg_host.sv
// Host controller model that drives the register port of the sensor bank.
`timescale 1ns/1ps
module reg_host (
   input wire logic sys_clk,
   output logic xfer_start,
   output logic [7:0] start_addr,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // Requests idle low from time zero, so nothing is taken during reset.
   initial begin
      xfer_start = 1'b0;
      start_addr = 8'h00;
      rd_strobe = 1'b0;
      wr_strobe = 1'b0;
      wr_data = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Loads the pointer; called just after an edge and returns just after the next.
   // Unused address and data lines carry the inverse, so a stale value never looks valid.
   task automatic start(input logic [7:0] addr);
      xfer_start = 1'b1;
      start_addr = addr;
      @(posedge sys_clk);
      #1;
      xfer_start = 1'b0;
      start_addr = ~addr;
   endtask : start

   // Writes one byte at the pointer, then lets one idle edge pass.
   // The idle edge keeps back-to-back writes from dropping and raising the strobe in one time step.
   task automatic wr(input logic [7:0] data);
      wr_strobe = 1'b1;
      wr_data = data;
      @(posedge sys_clk);
      #1;
      wr_strobe = 1'b0;
      wr_data = ~data;
      @(posedge sys_clk);
      #1;
   endtask : wr

   // Reads one byte; shape holds the valid flag after the taking edge and one edge later.
   task automatic rd(output logic [7:0] data, output logic [1:0] shape);
      rd_strobe = 1'b1;
      @(posedge sys_clk);
      #1;
      rd_strobe = 1'b0;
      data = rd_data;
      shape[1] = rd_valid;
      @(posedge sys_clk);
      #1;
      shape[0] = rd_valid;
   endtask : rd
endmodule : reg_host

//--- tb/tb.sv
// Self-checking testbench of the sensor register bank with a reference model.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   localparam logic [7:0] REV = 8'h10; // Revision 1.0 in BCD.
   localparam logic [7:0] IDENT = 8'h5a; // Value is arbitrary.
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic xfer_start, rd_strobe, wr_strobe, rd_valid, gate_error;
   logic [7:0] start_addr, wr_data, rd_data;
   logic [11:0] buf_y_sample, buf_z_sample, active_idle, dormant_idle, inactivity_count;
   logic [1:0] op_mode;
   logic [4:0] gate_error_count;
   logic [7:0] sensor_control_a, sensor_control_b, sensor_control_c, sensor_control_d, sensor_control_e;
   int miscompares = 0; // Mismatches seen.
   int num_checks = 0; // Comparisons made.
   int ptr; // Model of the register pointer.
   int seed_word; // Discarded result of seeding.
   logic [7:0] mreg [8'h15:8'h1f]; // Model of the writable registers.

   always #50 sys_clk = ~sys_clk;

   accel_config_register_bank #(.REVISION_CODE(REV), .IDENTITY_CODE(IDENT)) u_dut (.sys_clk(sys_clk),
      .rst(rst), .xfer_start(xfer_start), .start_addr(start_addr), .rd_strobe(rd_strobe),
      .wr_strobe(wr_strobe), .wr_data(wr_data), .buf_y_sample(buf_y_sample), .buf_z_sample(buf_z_sample),
      .op_mode(op_mode), .gate_error(gate_error), .gate_error_count(gate_error_count), .rd_data(rd_data),
      .rd_valid(rd_valid), .sensor_control_a(sensor_control_a), .sensor_control_b(sensor_control_b),
      .sensor_control_c(sensor_control_c), .sensor_control_d(sensor_control_d),
      .sensor_control_e(sensor_control_e), .active_idle(active_idle), .dormant_idle(dormant_idle),
      .inactivity_count(inactivity_count));
   reg_host u_host (.sys_clk(sys_clk), .xfer_start(xfer_start), .start_addr(start_addr),
      .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

   ////////////////////////////////////////////////////////////////////////////////
   // Expected read value at address a, from the model and the live inputs.
   function automatic logic [7:0] exp_rd(input int a);
      logic [11:0] s;
      logic ord;
      s = (a < 8'h10) ? buf_y_sample : buf_z_sample;
      ord = mreg[8'h16][accel_regs_pkg::B_BYTE_ORDER];
      case (a)
         8'h0e, 8'h10: return ord ? s[11:4] : s[7:0];
         8'h0f, 8'h11: return {4'h0, ord ? s[3:0] : s[11:8]};
         8'h12: return REV;
         8'h13: return IDENT;
         8'h14: return {gate_error, gate_error_count, op_mode};
         default: return (a >= 8'h15 && a <= 8'h1f) ? mreg[a] : 8'h00;
      endcase
   endfunction : exp_rd

   // Pointer after a read: buffer axes step in X, Y, Z order past skipped axes.
   function automatic int next_ptr(input int p);
      int i;
      logic fast;
      fast = mreg[8'h16][accel_regs_pkg::B_FAST_READ];
      if (p >= 8'h0c && p <= 8'h11) begin
         if (!p[0] && !fast) return p + 1;
         i = (p - 8'h0c) / 2;
         for (int k = 1; k <= 3; k++) begin
            if (!mreg[8'h19][5 - (i + k) % 3]) return 8'h0c + 2 * ((i + k) % 3);
         end
         return 8'h12;
      end
      return (p + 1) % 256;
   endfunction : next_ptr

   // Model write; a soft reset restores defaults, read-only places keep their content.
   task automatic mwrite(input int a, input logic [7:0] d);
      if (a == 8'h15 && d[7]) begin
         for (int r = 8'h15; r <= 8'h1f; r++) mreg[r] = (r == 8'h18) ? 8'h01 : 8'h00;
      end else if (a >= 8'h15 && a <= 8'h1f) begin
         mreg[a] = (a >= 8'h1b && a % 2 == 1) ? (d & 8'h0f) : d;
      end
   endtask : mwrite

   ////////////////////////////////////////////////////////////////////////////////
   // Bus operations that keep the model pointer in step with the design.
   task automatic do_start(input logic [7:0] a);
      u_host.start(a);
      ptr = a;
   endtask : do_start

   // Writes always advance the pointer by one, even where they are ignored.
   task automatic do_wr(input logic [7:0] d);
      u_host.wr(d);
      mwrite(ptr, d);
      ptr = (ptr + 1) % 256;
   endtask : do_wr

   task automatic do_rd(input int n);
      logic [7:0] d;
      logic [1:0] shape;
      repeat (n) begin
         u_host.rd(d, shape);
         `CHK(d, exp_rd(ptr))
         `CHK(shape, 2'b10)
         ptr = next_ptr(ptr);
      end
   endtask : do_rd

   // Compares the register outputs with the model.
   task automatic chk_outs;
      `CHK({sensor_control_a, sensor_control_b, sensor_control_c}, {mreg[8'h15], mreg[8'h16], mreg[8'h17]})
      `CHK({sensor_control_d, sensor_control_e}, {mreg[8'h18], mreg[8'h19]})
      `CHK(active_idle, {mreg[8'h1b][3:0], mreg[8'h1a]})
      `CHK(dormant_idle, {mreg[8'h1d][3:0], mreg[8'h1c]})
      `CHK(inactivity_count, {mreg[8'h1f][3:0], mreg[8'h1e]})
   endtask : chk_outs

   // New random samples and status; held steady while bytes are read.
   task automatic rnd_in;
      buf_y_sample = 12'($urandom);
      buf_z_sample = 12'($urandom);
      op_mode = 2'($urandom);
      gate_error = 1'($urandom);
      gate_error_count = 5'($urandom);
   endtask : rnd_in

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: the tests need under a thousand cycles, so this span of 20000 cycles means a hang.
   initial begin
      #(20000 * 100);
      miscompares++;
      test_done();
   end

   // Main sequence.
   initial begin
      logic [7:0] d;
      seed_word = $urandom(32'hd858);
      rnd_in();
      mwrite(8'h15, 8'h80);
      repeat (8) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      chk_outs();
      do_start(8'h12);
      do_rd(14);
      $display("test reset_values done");
      // Writes across read-only and writable places; the read-only ones must not move.
      do_start(8'h0e);
      for (int a = 8'h0e; a <= 8'h1f; a++) begin
         d = 8'($urandom);
         if (a == 8'h15) d[7] = 1'b0;
         if (a == 8'h1e) d[0] = 1'b1;
         do_wr(d);
      end
      chk_outs();
      do_start(8'h12);
      do_rd(14);
      $display("test write_readback done");
      // Every byte order, fast read and X/Y/Z skip setting; X reads as zero inside this bank.
      for (int m = 0; m < 32; m++) begin
         do_start(8'h16);
         do_wr({5'b00000, m[0], 1'b0, m[1]});
         do_start(8'h19);
         do_wr({2'b00, m[4], m[2], m[3], 3'b000});
         rnd_in();
         do_start(8'h0e);
         do_rd(6);
      end
      $display("test buffer_ports done");
      // Soft reset, then unmapped reads across the address wrap.
      do_start(8'h15);
      do_wr(8'h80);
      chk_outs();
      do_start(8'hff);
      do_rd(2);
      do_start(8'h15);
      do_rd(11);
      $display("test soft_reset done");
      test_done();
   end
endmodule : tb
